// ### verilog/lucc_defs.vh
// constants for the line unit channel control register bank
`ifndef LUCC_DEFS_VH
`define LUCC_DEFS_VH

`define LUCC_ADDR_W           5
`define LUCC_OFS_CTRL0        5'h00
`define LUCC_OFS_SEG0         5'h08
`define LUCC_NUM_SEG          8
`define LUCC_SEG_W            7
`define LUCC_CTRL0_RESET      8'h00
`define LUCC_SEG_RESET        7'h00
`define LUCC_BIT_PAT_TYPE     7
`define LUCC_BIT_PAT_DIR      6
`define LUCC_BIT_RX_ON        5
`define LUCC_EQ_MSB           4
`define LUCC_EQ_LSB           0
`define LUCC_EQ_SH_ARB        5'h0D
`define LUCC_EQ_GAIN_ARB      5'h13
`define LUCC_EQ_SH_FIRST      5'h08
`define LUCC_EQ_GAIN_FIRST    5'h0E
`define LUCC_EQ_GAIN_BUILD    5'h14
`define LUCC_EQ_E1_FIRST      5'h18
`define LUCC_PSEUDO_LEN       5'h0F
`define LUCC_QUASI_LEN        5'h14
// sensitivity codes
`define LUCC_SENS_36          2'h0
`define LUCC_SENS_45          2'h1
`define LUCC_SENS_15          2'h2
`define LUCC_SENS_29          2'h3
// haul codes
`define LUCC_HAUL_LONG        2'h0
`define LUCC_HAUL_SHORT       2'h1
`define LUCC_HAUL_GAIN        2'h2

`endif

// ### verilog/lucc_seg_mem.v
// eight pulse segment words with registered read
`timescale 1ns/1ps
`default_nettype none
`include "lucc_defs.vh"
module lucc_seg_mem (
   input  wire                     mclk,
   input  wire                     nrst,
   input  wire                     wr_en,
   input  wire [2:0]               wr_idx,
   input  wire [`LUCC_SEG_W-1:0]   wr_data,
   input  wire [2:0]               rd_idx,
   output reg  [`LUCC_SEG_W-1:0]   rd_data_q
);
   reg [`LUCC_SEG_W-1:0] mem_q [0:`LUCC_NUM_SEG-1];
   integer i;

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (i = 0; i < `LUCC_NUM_SEG; i = i + 1) begin
            mem_q[i] <= `LUCC_SEG_RESET;
         end
         rd_data_q <= `LUCC_SEG_RESET;
      end else begin
         if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
         end
         rd_data_q <= mem_q[rd_idx];
      end
   end
endmodule
`default_nettype wire

// ### verilog/lucc_top.v
// line unit channel control register and equalizer decode
`timescale 1ns/1ps
`default_nettype none
`include "lucc_defs.vh"
module lucc_top (
   input  wire                     mclk,
   input  wire                     nrst,
   input  wire [`LUCC_ADDR_W-1:0]  reg_addr,
   input  wire [7:0]               reg_wdata,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output reg  [7:0]               reg_rdata_q,
   output reg                      pattern_type_select_q,
   output reg  [4:0]               pattern_len_q,
   output reg                      pattern_to_rx_q,
   output reg                      pattern_to_tx_q,
   output reg                      receiver_on_q,
   output reg                      rx_power_down_q,
   output reg                      pll_enable_q,
   output reg  [4:0]               equalizer_code_q,
   output reg                      e1_mode_q,
   output reg  [1:0]               haul_mode_q,
   output reg  [1:0]               rx_sens_q,
   output reg  [1:0]               line_build_out_q,
   output reg  [2:0]               cable_band_q,
   output reg                      arb_pulse_q,
   output reg                      cable_coax_q,
   output reg  [2:0]               seg_idx_q,
   output reg  [`LUCC_SEG_W-1:0]   seg_amp_q
);

   // ----------------------------------------
   // register file
   // ----------------------------------------
   reg  [7:0] ctrl0_q;
   wire       seg_hit;
   wire       seg_wr;
   wire [2:0] seg_rd_idx;
   wire [`LUCC_SEG_W-1:0] seg_rd_data;
   reg        rd_seg_q;
   reg        rd_ctrl_q;

   assign seg_hit = ({reg_addr[`LUCC_ADDR_W-1:3], 3'h0} == `LUCC_OFS_SEG0);
   assign seg_wr  = reg_wr && seg_hit;
   // memory read port shared: bus reads win, otherwise the pulse sequencer walks the segments
   assign seg_rd_idx = (reg_rd && seg_hit) ? reg_addr[2:0] : seg_idx_q;

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl0_q <= `LUCC_CTRL0_RESET;
      end else if (reg_wr && reg_addr == `LUCC_OFS_CTRL0) begin
         ctrl0_q <= reg_wdata;
      end
   end

   lucc_seg_mem u_seg (
      .mclk      (mclk),
      .nrst      (nrst),
      .wr_en     (seg_wr),
      .wr_idx    (reg_addr[2:0]),
      .wr_data   (reg_wdata[`LUCC_SEG_W-1:0]),
      .rd_idx    (seg_rd_idx),
      .rd_data_q (seg_rd_data)
   );

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rd_seg_q  <= 1'b0;
         rd_ctrl_q <= 1'b0;
      end else begin
         rd_seg_q  <= reg_rd && seg_hit;
         rd_ctrl_q <= reg_rd && (reg_addr == `LUCC_OFS_CTRL0);
      end
   end

   // read data stand only in the cycle after the strobe; unmapped reads give zero
   always @* begin
      if (rd_ctrl_q) begin
         reg_rdata_q = ctrl0_q;
      end else if (rd_seg_q) begin
         reg_rdata_q = {1'b0, seg_rd_data};
      end else begin
         reg_rdata_q = 8'h00;
      end
   end

   // ----------------------------------------
   // equalizer decode
   // ----------------------------------------
   wire [4:0] eq_code = ctrl0_q[`LUCC_EQ_MSB:`LUCC_EQ_LSB];
   // band offsets; only the low bits are meaningful inside their own code range
   wire [4:0] gain_ofs = eq_code - `LUCC_EQ_GAIN_FIRST;
   wire [4:0] short_ofs = eq_code - `LUCC_EQ_SH_FIRST;
   reg        e1_d;
   reg  [1:0] haul_d;
   reg  [1:0] sens_d;
   reg  [1:0] build_d;
   reg  [2:0] band_d;
   reg        arb_d;
   reg        coax_d;

   always @* begin
      e1_d    = 1'b0;
      haul_d  = `LUCC_HAUL_LONG;
      sens_d  = `LUCC_SENS_36;
      build_d = 2'h0;
      band_d  = 3'h0;
      arb_d   = 1'b0;
      coax_d  = 1'b0;
      if (eq_code >= `LUCC_EQ_E1_FIRST) begin
         e1_d   = 1'b1;
         coax_d = ~eq_code[0];
         case (eq_code[2:1])
            2'h0: begin
               haul_d = `LUCC_HAUL_LONG;
               sens_d = `LUCC_SENS_36;
            end
            2'h1: begin
               haul_d = `LUCC_HAUL_LONG;
               sens_d = `LUCC_SENS_45;
            end
            2'h2: begin
               haul_d = `LUCC_HAUL_SHORT;
               sens_d = `LUCC_SENS_15;
            end
            default: begin
               haul_d = `LUCC_HAUL_GAIN;
               sens_d = `LUCC_SENS_29;
            end
         endcase
      end else if (eq_code >= `LUCC_EQ_GAIN_BUILD) begin
         haul_d  = `LUCC_HAUL_GAIN;
         sens_d  = `LUCC_SENS_29;
         build_d = eq_code[1:0];
      end else if (eq_code >= `LUCC_EQ_GAIN_FIRST) begin
         haul_d = `LUCC_HAUL_GAIN;
         sens_d = `LUCC_SENS_29;
         arb_d  = (eq_code == `LUCC_EQ_GAIN_ARB);
         band_d = gain_ofs[2:0];
      end else if (eq_code >= `LUCC_EQ_SH_FIRST) begin
         haul_d = `LUCC_HAUL_SHORT;
         sens_d = `LUCC_SENS_15;
         arb_d  = (eq_code == `LUCC_EQ_SH_ARB);
         band_d = short_ofs[2:0];
      end else begin
         haul_d  = `LUCC_HAUL_LONG;
         sens_d  = eq_code[2] ? `LUCC_SENS_45 : `LUCC_SENS_36;
         build_d = eq_code[1:0];
      end
      if (arb_d) begin
         band_d = 3'h0;
      end
   end

   // ----------------------------------------
   // outputs and arbitrary pulse sequencer
   // ----------------------------------------
   wire rx_on = ctrl0_q[`LUCC_BIT_RX_ON];

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pattern_type_select_q <= 1'b0;
         pattern_len_q         <= `LUCC_PSEUDO_LEN;
         pattern_to_rx_q       <= 1'b1;
         pattern_to_tx_q       <= 1'b0;
         receiver_on_q         <= 1'b0;
         rx_power_down_q       <= 1'b1;
         pll_enable_q          <= 1'b1;
         equalizer_code_q      <= 5'h00;
         e1_mode_q             <= 1'b0;
         haul_mode_q           <= `LUCC_HAUL_LONG;
         rx_sens_q             <= `LUCC_SENS_36;
         line_build_out_q      <= 2'h0;
         cable_band_q          <= 3'h0;
         arb_pulse_q           <= 1'b0;
         cable_coax_q          <= 1'b0;
         seg_idx_q             <= 3'h0;
         seg_amp_q             <= `LUCC_SEG_RESET;
      end else begin
         pattern_type_select_q <= ctrl0_q[`LUCC_BIT_PAT_TYPE];
         pattern_len_q         <= ctrl0_q[`LUCC_BIT_PAT_TYPE] ? `LUCC_QUASI_LEN : `LUCC_PSEUDO_LEN;
         pattern_to_rx_q       <= ~ctrl0_q[`LUCC_BIT_PAT_DIR];
         pattern_to_tx_q       <= ctrl0_q[`LUCC_BIT_PAT_DIR];
         receiver_on_q         <= rx_on;
         rx_power_down_q       <= ~rx_on;
         pll_enable_q          <= 1'b1;
         equalizer_code_q      <= eq_code;
         e1_mode_q             <= e1_d;
         haul_mode_q           <= haul_d;
         rx_sens_q             <= sens_d;
         line_build_out_q      <= build_d;
         cable_band_q          <= band_d;
         arb_pulse_q           <= arb_d;
         cable_coax_q          <= coax_d;
         // walk the eight segments while arbitrary pulse is chosen; a bus segment read borrows
         // the read port, so the index holds then and the borrowed word is never shown as amplitude
         if (arb_d) begin
            if (!(reg_rd && seg_hit)) begin
               seg_idx_q <= seg_idx_q + 3'h1;
            end
            if (!rd_seg_q) begin
               seg_amp_q <= seg_rd_data;
            end
         end else begin
            seg_idx_q <= 3'h0;
            seg_amp_q <= `LUCC_SEG_RESET;
         end
      end
   end

endmodule
`default_nettype wire

// ### verification/lucc_checker.sv
// concurrent checks on the line unit channel control ports
`timescale 1ns/1ps
`default_nettype none
`include "lucc_defs.vh"
module lucc_checker (
   input wire logic                    mclk,
   input wire logic                    nrst,
   input wire logic [`LUCC_ADDR_W-1:0] reg_addr,
   input wire logic [7:0]              reg_wdata,
   input wire logic                    reg_wr,
   input wire logic                    reg_rd,
   input wire logic [7:0]              reg_rdata_q,
   input wire logic                    pattern_type_select_q,
   input wire logic [4:0]              pattern_len_q,
   input wire logic                    pattern_to_rx_q,
   input wire logic                    pattern_to_tx_q,
   input wire logic                    receiver_on_q,
   input wire logic                    rx_power_down_q,
   input wire logic                    pll_enable_q,
   input wire logic [4:0]              equalizer_code_q,
   input wire logic                    e1_mode_q,
   input wire logic                    arb_pulse_q,
   input wire logic                    cable_coax_q
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // decoded outputs trail a control write by two edges
   sequence s_ctrl_wr;
      reg_wr && reg_addr == 5'h00;
   endsequence
   sequence s_ctrl_rd;
      reg_rd && reg_addr == 5'h00;
   endsequence
   a_ctrl_read_back: assert property (s_ctrl_wr ##1 s_ctrl_rd |=> reg_rdata_q == $past(reg_wdata, 2))
      else $error("control read back differs from write");
   a_eq_code_wr: assert property (s_ctrl_wr |-> ##2 equalizer_code_q == $past(reg_wdata[4:0], 2))
      else $error("equalizer code not taken from write");
   a_rx_on_wr: assert property (s_ctrl_wr |-> ##2 receiver_on_q == $past(reg_wdata[5], 2) && rx_power_down_q != receiver_on_q)
      else $error("receive section control wrong");
   a_pll_kept_on: assert property (pll_enable_q)
      else $error("clock pll switched off");
   a_pat_dir_wr: assert property (s_ctrl_wr |-> ##2 pattern_to_tx_q == $past(reg_wdata[6], 2) && pattern_to_rx_q == !pattern_to_tx_q)
      else $error("pattern direction wrong");
   a_pat_type_wr: assert property (s_ctrl_wr |-> ##2 pattern_type_select_q == $past(reg_wdata[7], 2))
      else $error("pattern type not taken from write");
   a_pat_len: assert property (pattern_len_q == (pattern_type_select_q ? 5'h14 : 5'h0F))
      else $error("pattern length does not match type");
   a_arb_decode: assert property (arb_pulse_q == (equalizer_code_q == 5'h0D || equalizer_code_q == 5'h13))
      else $error("arbitrary pulse decode wrong");
   a_e1_coax: assert property (e1_mode_q == (equalizer_code_q >= 5'h18) && cable_coax_q == (e1_mode_q && !equalizer_code_q[0]))
      else $error("e1 or cable decode wrong");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
      else $error("read data outside read cycle");
endmodule
bind lucc_top lucc_checker lucc_checker_i (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
   .pattern_type_select_q, .pattern_len_q, .pattern_to_rx_q, .pattern_to_tx_q, .receiver_on_q, .rx_power_down_q,
   .pll_enable_q, .equalizer_code_q, .e1_mode_q, .arb_pulse_q, .cable_coax_q);
`default_nettype wire

// ### verification/tb_lucc_top.sv
// self-checking bench for the line unit channel control register
`timescale 1ns/1ps
`default_nettype none
`include "lucc_defs.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_lucc_top;
   logic       mclk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic [4:0] reg_addr = 5'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata_q, mask;
   logic       pattern_type_select_q, pattern_to_rx_q, pattern_to_tx_q, receiver_on_q, rx_power_down_q;
   logic       pll_enable_q, e1_mode_q, arb_pulse_q, cable_coax_q;
   logic [4:0] pattern_len_q, equalizer_code_q, c;
   logic [1:0] haul_mode_q, rx_sens_q, line_build_out_q, h, s;
   logic [2:0] cable_band_q, seg_idx_q;
   logic [6:0] seg_amp_q;
   int         n_errors = 0, checked = 0, cyc = 0;
   lucc_top lucc_top_i (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .pattern_type_select_q,
      .pattern_len_q, .pattern_to_rx_q, .pattern_to_tx_q, .receiver_on_q, .rx_power_down_q, .pll_enable_q,
      .equalizer_code_q, .e1_mode_q, .haul_mode_q, .rx_sens_q, .line_build_out_q, .cable_band_q, .arb_pulse_q,
      .cable_coax_q, .seg_idx_q, .seg_amp_q);
   // ----------------------------------------
   // clock, watchdog, bus tasks
   // ----------------------------------------
   initial forever #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict;
      end
   end
   task give_verdict;
      $display("errors %0d of %0d checks", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask
   task rd(input logic [4:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1 `CHK("read data", e, reg_rdata_q)
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      `CHK("reset outputs", 8'hEF, {pattern_to_rx_q, rx_power_down_q, pll_enable_q, pattern_len_q})
      rd(5'h00, 8'h00);
   endtask
   task t_codes;
      for (int i = 0; i < 32; i++) begin
         c = i[4:0];
         wr(5'h00, {i[2:0], c});
         // second edge lets the decoded outputs land
         @(posedge mclk);
         #1;
         if (c >= 5'h18) begin
            h = (c[2:1] == 2'h3) ? 2'h2 : {1'h0, c[2:1] == 2'h2};
            s = c[2:1];
         end
         else if (c < 5'h08) {h, s} = {2'h0, 1'h0, c[2]};
         else if (c < 5'h0E) {h, s} = 4'h6;
         else {h, s} = 4'hB;
         `CHK("decode", {c >= 5'h18, h, s, c == 5'h0D || c == 5'h13, c >= 5'h18 && !c[0]},
            {e1_mode_q, haul_mode_q, rx_sens_q, arb_pulse_q, cable_coax_q})
         `CHK("control", {i[2], i[2] ? 5'h14 : 5'h0F, !i[1], i[1], i[0], !i[0], c}, {pattern_type_select_q, pattern_len_q,
            pattern_to_rx_q, pattern_to_tx_q, receiver_on_q, rx_power_down_q, equalizer_code_q})
         if (c < 5'h08 || (c >= 5'h14 && c < 5'h18)) `CHK("build out", c[1:0], line_build_out_q)
         if (c >= 5'h08 && c < 5'h0D) `CHK("band", c[2:0] - 3'h0, cable_band_q)
         if (c >= 5'h0E && c < 5'h13) `CHK("band", c[2:0] - 3'h6, cable_band_q)
         rd(5'h00, {i[2:0], c});
      end
   endtask
   task t_segments;
      for (int k = 0; k < 8; k++) wr(5'h08 + k[4:0], {1'h1, k[2:0], 4'hA});
      for (int k = 0; k < 8; k++) rd(5'h08 + k[4:0], {1'h0, k[2:0], 4'hA});
      wr(5'h00, 8'h13);
      mask = 8'h00;
      repeat (20) begin
         @(posedge mclk);
         #1 mask = mask | (8'h01 << seg_amp_q[6:4]);
      end
      `CHK("segments seen", 8'hFF, mask)
      c = {2'h0, seg_idx_q};
      @(posedge mclk);
      #1 `CHK("segment step", c[2:0] + 3'h1, seg_idx_q)
   endtask
   // write then read with no gap between the strobes
   task t_back_to_back;
      @(posedge mclk);
      reg_addr <= 5'h00;
      reg_wdata <= 8'hA9;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1 `CHK("read after write", 8'hA9, reg_rdata_q)
      `CHK("sequencer idle", 10'h000, {seg_idx_q, seg_amp_q})
   endtask
   task t_unmapped;
      wr(5'h01, 8'hFF);
      rd(5'h01, 8'h00);
      rd(5'h10, 8'h00);
      rd(5'h00, 8'h13);
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      nrst <= 1'h1;
      @(posedge mclk);
      #1 t_reset;
      t_codes;
      t_segments;
      t_unmapped;
      t_back_to_back;
      give_verdict;
   end
endmodule
`undef CHK
`default_nettype wire
